// [verilog/peripheral_pin_routing.sv]
// Pin routing block: input selections, pin output selections and lock logic.
// Assumes a plain strobe register port, a power-on reset apart from the
// ordinary reset, and pin levels already synchronous to clk.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - Only digital signals are routed; analog functions stay on fixed pins.
// - Every peripheral input has its own selection; sharing one pin is fine.
// - Port data reads return the real pin level regardless of selections.
// - Each of the 17 routed pins has an output selection; direction_control normally enables the driver.
// - Synchronous usart, I2C and auto-shutdown override direction_control when routed.
// - While routing_locked is set no selection changes; bits 7-1 read zero.
// - Lock bit changes only after writing 0x55 then 0xAA to the lock register.
// - With one_way_lock_fuse, the lock sets once per reset; then stays locked.
// - Sleep entry and exit leave all selections unchanged.
// - Only power-on reset restores selection defaults; other resets keep them.
// - Input selections use bits 4-0; bits 7-5 read zero; keep over ordinary resets.
// - Codes 00000-00101 pick port A 0-5, 10000-10101 port C 0-5.
// - Larger variant adds 01100-01111 port B 4-7 and 10110-10111 port C 6-7.
// - Output code 0 drives latch; 01000-01111 complementary, capture-compare and pwm outputs.
// - Output codes 10000-10111 except 10011 serial and comparator sources; rest reserved.
module peripheral_pin_routing
  import pin_routing_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              por,
  input  wire logic              clk_en,
  input  wire logic              one_way_lock_fuse,
  input  wire logic [5:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic [N_PIN-1:0]  pin_in,
  input  wire logic [N_PIN-1:0]  analog_select,
  input  wire logic [N_PIN-1:0]  output_latch,
  input  wire logic [N_PIN-1:0]  direction_control,
  input  wire logic [15:0]       periph_out,
  input  wire logic              sync_usart_active,
  input  wire logic              usart_drive,
  input  wire logic              i2c_drive,
  input  wire logic              shutdown_active,
  input  wire logic              shutdown_drive,
  output logic      [N_IN-1:0]   periph_in,
  output logic      [N_OUT-1:0]  pin_out,
  output logic      [N_OUT-1:0]  pin_oe
);

  // Pin indices of each routed output pin: A0 A1 A2 A4 A5 B4-B7 C0-C7
  localparam logic [17*5-1:0] OUT_PIN_IDX = {5'd23, 5'd22, 5'd21, 5'd20, 5'd19, 5'd18, 5'd17, 5'd16,
                                              5'd15, 5'd14, 5'd13, 5'd12, 5'd5, 5'd4, 5'd2, 5'd1, 5'd0};

  logic [4:0]  in_sel_q  [N_IN];
  logic [4:0]  out_sel_q [N_OUT];
  logic        locked_q;
  logic        relock_spent_q;
  lock_state_t lk_state_q;
  logic [7:0]  rdata_q;
  logic [N_PIN-1:0] digital_in;

  // Map an input code to a pin index; reserved codes give an out-of-range index
  function automatic logic [5:0] in_code_to_pin(input logic [4:0] code);
    logic [5:0] idx;
    idx = 6'h3F;
    if (code <= 5'h05) idx = {1'b0, code};
    else if (code >= 5'h0C && code <= 5'h0F) idx = {3'b001, code[2:0]};
    else if (code >= 5'h10 && code <= 5'h17) idx = {3'b010, code[2:0]};
    return idx;
  endfunction

  // Decoding of an address in the selection window, used by the read port for inputs and outputs
  function automatic logic sel_write(input logic [5:0] addr, input logic [5:0] base, input int n);
    return (addr >= base) && (addr < base + 6'(n));
  endfunction

  // Digital input buffer is off for analog pins, which then read as 0
  assign digital_in = pin_in & ~analog_select;

  // Lock sequence; any access that breaks the run of writes aborts it
  always_ff @(posedge clk) begin
    if (por) begin
      lk_state_q <= LK_IDLE;
    end else if (reset) begin
      lk_state_q <= LK_IDLE;
    end else if (clk_en) begin
      case (lk_state_q)
        LK_IDLE: begin
          if (reg_wr && reg_addr == ADDR_LOCK && reg_wdata == KEY_FIRST) lk_state_q <= LK_KEY1;
        end
        LK_KEY1: begin
          if (reg_wr && reg_addr == ADDR_LOCK && reg_wdata == KEY_SECOND) lk_state_q <= LK_KEY2;
          else if (reg_wr && reg_addr == ADDR_LOCK && reg_wdata == KEY_FIRST) lk_state_q <= LK_KEY1;
          else if (reg_wr || reg_rd) lk_state_q <= LK_IDLE;
          else lk_state_q <= LK_IDLE;
        end
        LK_KEY2: lk_state_q <= LK_IDLE;
        default: lk_state_q <= LK_IDLE;
      endcase
    end
  end

  // Lock bit and one-way bookkeeping; ordinary reset also clears them
  always_ff @(posedge clk) begin
    if (por || reset) begin
      locked_q       <= 1'b0;
      relock_spent_q <= 1'b0;
    end else if (clk_en && lk_state_q == LK_KEY2 && reg_wr && reg_addr == ADDR_LOCK) begin
      if (reg_wdata[LOCK_BIT]) begin
        locked_q <= 1'b1;
        if (one_way_lock_fuse) relock_spent_q <= 1'b1;
      end else if (!(one_way_lock_fuse && relock_spent_q)) begin
        locked_q <= 1'b0;
      end
    end
  end

  // Selections reset on power-on only; ordinary reset and sleep leave them
  generate
    for (genvar i = 0; i < N_IN; i++) begin : g_in
      always_ff @(posedge clk) begin
        if (por) begin
          in_sel_q[i] <= IN_SEL_RESET[i*5 +: 5];
        end else if (clk_en && reg_wr && !locked_q && reg_addr == ADDR_IN_BASE + 6'(i)) begin
          in_sel_q[i] <= reg_wdata[4:0];
        end
      end
      // Each input looks up its own pin, so many may share one
      always_comb begin
        logic [5:0] p;
        p = in_code_to_pin(in_sel_q[i]);
        periph_in[i] = (p < 6'(N_PIN)) ? digital_in[p[4:0]] : 1'b0;
      end
    end
    for (genvar j = 0; j < N_OUT; j++) begin : g_out
      localparam logic [4:0] PIN = OUT_PIN_IDX[j*5 +: 5];
      always_ff @(posedge clk) begin
        if (por) begin
          out_sel_q[j] <= OUT_SEL_RESET;
        end else if (clk_en && reg_wr && !locked_q && reg_addr == ADDR_OUT_BASE + 6'(j)) begin
          out_sel_q[j] <= reg_wdata[4:0];
        end
      end
      pin_output_mux u_mux (
        .sel               (out_sel_q[j]),
        .latch_bit         (output_latch[PIN]),
        .dir_input         (direction_control[PIN]),
        .periph_out        (periph_out),
        .sync_usart_active (sync_usart_active),
        .usart_drive       (usart_drive),
        .i2c_drive         (i2c_drive),
        .shutdown_active   (shutdown_active),
        .shutdown_drive    (shutdown_drive),
        .pin_level         (pin_out[j]),
        .pin_oe            (pin_oe[j])
      );
    end
  endgenerate

  // Read port; unmapped addresses read 0
  always_ff @(posedge clk) begin
    if (reset || por) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= 8'h00;
      if (reg_rd) begin
        if (reg_addr == ADDR_LOCK) rdata_q <= {7'h00, locked_q};
        else if (sel_write(reg_addr, ADDR_IN_BASE, N_IN))
          rdata_q <= {3'h0, in_sel_q[4'(reg_addr - ADDR_IN_BASE)]};
        else if (sel_write(reg_addr, ADDR_OUT_BASE, N_OUT))
          rdata_q <= {3'h0, out_sel_q[5'(reg_addr - ADDR_OUT_BASE)]};
        else if (reg_addr >= ADDR_PORT_BASE && reg_addr <= ADDR_PORT_LAST)
          rdata_q <= digital_in[(reg_addr - ADDR_PORT_BASE) * 8 +: 8];
      end
    end
  end
  assign reg_rdata = rdata_q;

  // A write accepted while locked must not move a selection
  AST_LOCKED_HOLDS: assert property (@(posedge clk) disable iff (reset || por)
    locked_q && clk_en && reg_wr |=> $stable(out_sel_q[0]) && $stable(in_sel_q[0]))
    else $error("selection changed while locked");

  AST_KEYS_SET: assert property (@(posedge clk) disable iff (reset || por)
    clk_en && lk_state_q == LK_IDLE && reg_wr && reg_addr == ADDR_LOCK && reg_wdata == KEY_FIRST
    |=> lk_state_q == LK_KEY1)
    else $error("first key not taken");

  AST_ONE_WAY: assert property (@(posedge clk) disable iff (reset || por)
    one_way_lock_fuse && relock_spent_q && locked_q |=> locked_q)
    else $error("one-way lock cleared");

  AST_LOCK_RD_ZERO: assert property (@(posedge clk) disable iff (reset || por)
    clk_en && reg_rd && reg_addr == ADDR_LOCK |=> reg_rdata[7:1] == 7'h00 && reg_rdata[0] == $past(locked_q))
    else $error("lock read wrong");

  AST_NO_SEQ_NO_LOCK: assert property (@(posedge clk) disable iff (reset || por)
    lk_state_q != LK_KEY2 && !locked_q |=> !locked_q)
    else $error("lock set without keys");

  AST_RESET_KEEPS: assert property (@(posedge clk) disable iff (por)
    reset |=> $stable(out_sel_q[0]) || $past(clk_en && reg_wr))
    else $error("ordinary reset moved selection");

  AST_SEL_RD_HIGH_ZERO: assert property (@(posedge clk) disable iff (reset || por)
    clk_en && reg_rd && reg_addr == ADDR_IN_BASE |=> reg_rdata[7:5] == 3'h0)
    else $error("input select high bits not zero");

  AST_PORT_READ: assert property (@(posedge clk) disable iff (reset || por)
    clk_en && reg_rd && reg_addr == ADDR_PORT_BASE |=> reg_rdata == $past(digital_in[7:0]))
    else $error("port read not pin level");

  // A reserved input code must never pass a pin level to the peripheral
  AST_RESERVED_IN_ZERO: assert property (@(posedge clk) disable iff (reset || por)
    (in_sel_q[0] >= 5'h06 && in_sel_q[0] <= 5'h0B) || in_sel_q[0] >= 5'h18 |-> !periph_in[0])
    else $error("reserved input code passed a level");

  // Sleep is modelled by a low clock enable: lock state must not move
  AST_FROZEN_LOCK: assert property (@(posedge clk) disable iff (reset || por)
    !clk_en |=> $stable(locked_q) && $stable(lk_state_q))
    else $error("lock state moved while frozen");

endmodule

// [verilog/pin_routing_pkg.sv]
// Package for the pin routing block: register map, field layout, codes.
// Assumes one clock domain and a plain strobe register port.
package pin_routing_pkg;

  // Register indices (byte addresses on the plain port)
  localparam logic [5:0] ADDR_LOCK      = 6'h00;
  localparam logic [5:0] ADDR_IN_BASE   = 6'h01;  // 9 input selections at 0x01..0x09
  localparam logic [5:0] ADDR_OUT_BASE  = 6'h10;  // 17 pin output selections at 0x10..0x20
  localparam logic [5:0] ADDR_PORT_BASE = 6'h28;  // port A, B, C pin levels at 0x28..0x2A
  localparam logic [5:0] ADDR_PORT_LAST = 6'h2A;

  localparam int N_IN  = 9;
  localparam int N_OUT = 17;
  localparam int N_PIN = 24;  // 8 pins on each of ports A, B, C

  // Field layout
  localparam int SEL_W      = 5;
  localparam int LOCK_BIT   = 0;

  // Unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Reset values
  localparam logic [4:0] OUT_SEL_RESET = 5'h00;
  // Power-on defaults of the inputs: RA2, RA5, RA4, RC4, RC5, RC5, RC0, RC1, RC3
  localparam logic [9*5-1:0] IN_SEL_RESET = {5'h13, 5'h11, 5'h10, 5'h15, 5'h15,
                                             5'h14, 5'h04, 5'h05, 5'h02};

  // Output source codes
  localparam logic [4:0] OUT_LATCH    = 5'h00;
  localparam logic [4:0] OUT_COMP_A   = 5'h08;
  localparam logic [4:0] OUT_COMP_B   = 5'h09;
  localparam logic [4:0] OUT_COMP_C   = 5'h0A;
  localparam logic [4:0] OUT_COMP_D   = 5'h0B;
  localparam logic [4:0] OUT_CAPTURE_COMPARE_1     = 5'h0C;
  localparam logic [4:0] OUT_CAPTURE_COMPARE_2     = 5'h0D;
  localparam logic [4:0] OUT_PWM3     = 5'h0E;
  localparam logic [4:0] OUT_PWM4     = 5'h0F;
  localparam logic [4:0] OUT_SCK_SCL  = 5'h10;
  localparam logic [4:0] OUT_SDA      = 5'h11;
  localparam logic [4:0] OUT_SDO      = 5'h12;
  localparam logic [4:0] OUT_ASYNC_TX_OR_SYNC_CLK    = 5'h14;
  localparam logic [4:0] OUT_DT       = 5'h15;
  localparam logic [4:0] OUT_CMP1     = 5'h16;
  localparam logic [4:0] OUT_CMP2     = 5'h17;

  // Lock sequence states
  typedef enum logic [1:0] {LK_IDLE, LK_KEY1, LK_KEY2} lock_state_t;

endpackage

// [verilog/pin_output_mux.sv]
// One pin's output multiplexer: source choice and driver enable.
// Assumes peripheral outputs and override requests are synchronous to clk.
`timescale 1ns/1ps
module pin_output_mux
  import pin_routing_pkg::*;
(
  input  wire logic [4:0]  sel,
  input  wire logic        latch_bit,
  input  wire logic        dir_input,
  input  wire logic [15:0] periph_out,
  input  wire logic        sync_usart_active,
  input  wire logic        usart_drive,
  input  wire logic        i2c_drive,
  input  wire logic        shutdown_active,
  input  wire logic        shutdown_drive,
  output logic             pin_level,
  output logic             pin_oe
);

  // Source pick; reserved codes fall back to the latch so the pin never floats undefined
  always_comb begin
    pin_level = latch_bit;
    pin_oe    = ~dir_input;
    case (sel)
      OUT_LATCH:   pin_level = latch_bit;
      OUT_COMP_A:  pin_level = periph_out[0];
      OUT_COMP_B:  pin_level = periph_out[1];
      OUT_COMP_C:  pin_level = periph_out[2];
      OUT_COMP_D:  pin_level = periph_out[3];
      OUT_CAPTURE_COMPARE_1:    pin_level = periph_out[4];
      OUT_CAPTURE_COMPARE_2:    pin_level = periph_out[5];
      OUT_PWM3:    pin_level = periph_out[6];
      OUT_PWM4:    pin_level = periph_out[7];
      OUT_SCK_SCL: pin_level = periph_out[8];
      OUT_SDA:     pin_level = periph_out[9];
      OUT_SDO:     pin_level = periph_out[10];
      OUT_ASYNC_TX_OR_SYNC_CLK:   pin_level = periph_out[11];
      OUT_DT:      pin_level = periph_out[12];
      OUT_CMP1:    pin_level = periph_out[13];
      OUT_CMP2:    pin_level = periph_out[14];
      default:     pin_level = latch_bit;
    endcase
    // Peripherals that own the driver override direction_control
    case (sel)
      OUT_ASYNC_TX_OR_SYNC_CLK, OUT_DT: begin
        if (sync_usart_active) pin_oe = usart_drive;
      end
      OUT_SCK_SCL, OUT_SDA: begin
        if (periph_out[15]) pin_oe = i2c_drive;
      end
      OUT_COMP_A, OUT_COMP_B, OUT_COMP_C, OUT_COMP_D: begin
        if (shutdown_active) pin_oe = shutdown_drive;
      end
      default: pin_oe = ~dir_input;
    endcase
  end

endmodule

// [bench/io_world_model.sv]
// Far-side model: pads and on-chip peripherals around the routing block.
// Assumes one clock; fresh levels appear only when the bench asks for them.
`timescale 1ns/1ps
module io_world_model (
  input  wire logic        clk,
  input  wire logic        step,
  output logic      [23:0] pin_in = 24'h000000,
  output logic      [15:0] periph_out = 16'h0000,
  output logic      [23:0] analog_select
);
  int seed = 32'hA44E;
  // Every pin kept digital so routed inputs see the pad level
  assign analog_select = 24'h000000;
  // New pad and peripheral levels; the I2C driver request bit stays low,
  // so it never steals a pin the bench is watching
  always @(posedge clk) begin
    if (step) begin
      pin_in <= 24'($random(seed));
      periph_out <= 16'($random(seed)) & 16'h7FFF;
    end
  end
endmodule

// [bench/testbench.sv]
// Self-checking bench for the pin routing block.
// Assumes the register map and reset codes of pin_routing_pkg.
`timescale 1ns/1ps
module testbench
  import pin_routing_pkg::*;
;
  logic clk = 0, reset = 1, por = 1, clk_en = 1, one_way_lock_fuse = 0, step = 0;
  logic [5:0]  reg_addr = 6'h00;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic        reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [23:0] pin_in, analog_select, output_latch = 24'h000000, direction_control = 24'hFFFFFF;
  logic [15:0] periph_out;
  logic        sync_usart_active = 0, usart_drive = 0, i2c_drive = 0;
  logic        shutdown_active = 0, shutdown_drive = 0;
  logic [8:0]  periph_in;
  logic [16:0] pin_out, pin_oe;
  logic [7:0]  exp_q[$];
  int          err_total = 0, checks_done = 0;
  int          seed = 32'hA44E;

  peripheral_pin_routing dut (.clk, .reset, .por, .clk_en, .one_way_lock_fuse, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pin_in, .analog_select, .output_latch, .direction_control, .periph_out,
    .sync_usart_active, .usart_drive, .i2c_drive, .shutdown_active, .shutdown_drive, .periph_in,
    .pin_out, .pin_oe);
  io_world_model u_world (.clk, .step, .pin_in, .periph_out, .analog_select);

  always #10 clk = ~clk;

  task automatic check(logic [7:0] seen, logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic wr(logic [5:0] a, logic [7:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask

  // Expected read data is noted now and compared when it appears
  task automatic rd(logic [5:0] a, logic [7:0] want);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    exp_q.push_back(want);
    @(posedge clk);
  endtask

  // Drop the strobes and let the last access land before looking
  task automatic idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic lock_seq(logic [7:0] d);
    wr(ADDR_LOCK, KEY_FIRST);
    wr(ADDR_LOCK, KEY_SECOND);
    wr(ADDR_LOCK, d);
    idle;
  endtask

  // Output codes map onto periph_out bits, skipping the reserved 10011
  function automatic int src_bit(int c);
    return c < 19 ? c - 8 : c - 9;
  endfunction

  task report_and_stop;
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d)
      check(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd & clk_en;
  end

  // Whole sequence needs a few hundred cycles; this is ample
  initial begin
    #(20 * 20000);
    err_total++;
    report_and_stop;
  end

  initial begin
    int  c;
    logic ev;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    rd(ADDR_LOCK, 8'h00);
    for (c = 0; c < N_IN; c++) rd(6'(ADDR_IN_BASE + c), {3'b000, IN_SEL_RESET[c*5 +: 5]});
    for (c = 0; c < N_OUT; c++) rd(6'(ADDR_OUT_BASE + c), 8'h00);
    wr(ADDR_IN_BASE, 8'hFF);
    rd(ADDR_IN_BASE, 8'h1F);
    // Random pad levels, then every input code on two peripherals at once
    idle;
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    output_latch <= 24'($random(seed));
    direction_control <= 24'hFFFFFE;
    @(posedge clk);
    for (c = 0; c < 32; c++) begin
      wr(ADDR_IN_BASE, 8'(c));
      wr(6'(ADDR_IN_BASE + 1), 8'(c));
      idle;
      ev = (c <= 5 || (c >= 12 && c <= 23)) ? pin_in[c] : 1'b0;
      check(8'(periph_in[0]), 8'(ev));
      check(8'(periph_in[1]), 8'(ev));
    end
    for (c = 0; c < 3; c++) rd(6'(ADDR_PORT_BASE + c), pin_in[c*8 +: 8]);
    // Every output code on the first pin; reserved codes fall back to the latch
    for (c = 0; c < 32; c++) begin
      wr(ADDR_OUT_BASE, 8'(c));
      idle;
      ev = (c >= 8 && c <= 23 && c != 19) ? periph_out[src_bit(c)] : output_latch[0];
      check(8'(pin_out[0]), 8'(ev));
      check(8'({pin_oe[1], pin_oe[0]}), 8'h01);
    end
    // Untouched pins still follow their own latch bit: C7 and B4
    check(8'({pin_out[16], pin_out[5]}), 8'({output_latch[23], output_latch[12]}));
    // Synchronous usart takes the driver from a pin set as input
    direction_control <= 24'hFFFFFF;
    sync_usart_active <= 1'b1;
    usart_drive <= 1'b1;
    wr(6'(ADDR_IN_BASE + 7), 8'h00);
    wr(ADDR_OUT_BASE, 8'(OUT_ASYNC_TX_OR_SYNC_CLK));
    idle;
    check(8'(pin_oe[0]), 8'h01);
    wr(ADDR_OUT_BASE, 8'(OUT_LATCH));
    idle;
    check(8'(pin_oe[0]), 8'h00);
    sync_usart_active <= 1'b0;
    // Auto-shutdown takes the driver of a complementary output pin
    shutdown_active <= 1'b1;
    shutdown_drive <= 1'b1;
    wr(ADDR_OUT_BASE, 8'(OUT_COMP_A));
    idle;
    check(8'(pin_oe[0]), 8'h01);
    shutdown_active <= 1'b0;
    // Locked selections refuse writes; a read between keys spoils the sequence
    lock_seq(8'h01);
    wr(6'(ADDR_OUT_BASE + 2), 8'h0C);
    wr(6'(ADDR_IN_BASE + 2), 8'h00);
    rd(6'(ADDR_OUT_BASE + 2), 8'h00);
    rd(6'(ADDR_IN_BASE + 2), {3'b000, IN_SEL_RESET[14:10]});
    wr(ADDR_LOCK, KEY_FIRST);
    rd(ADDR_LOCK, 8'h01);
    wr(ADDR_LOCK, KEY_SECOND);
    wr(ADDR_LOCK, 8'h00);
    rd(ADDR_LOCK, 8'h01);
    lock_seq(8'h00);
    rd(ADDR_LOCK, 8'h00);
    lock_seq(8'hFF);
    rd(ADDR_LOCK, 8'h01);
    lock_seq(8'h00);
    // A frozen clock enable stands in for Sleep: nothing is taken
    clk_en <= 1'b0;
    wr(6'(ADDR_OUT_BASE + 3), 8'h0E);
    idle;
    clk_en <= 1'b1;
    rd(6'(ADDR_OUT_BASE + 3), 8'h00);
    wr(6'(ADDR_OUT_BASE + 3), 8'h0E);
    lock_seq(8'h01);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(ADDR_LOCK, 8'h00);
    rd(6'(ADDR_OUT_BASE + 3), 8'h0E);
    // With the fuse, the first keyed set is final until reset
    one_way_lock_fuse <= 1'b1;
    lock_seq(8'h01);
    lock_seq(8'h00);
    wr(6'(ADDR_OUT_BASE + 3), 8'h00);
    rd(ADDR_LOCK, 8'h01);
    rd(6'(ADDR_OUT_BASE + 3), 8'h0E);
    idle;
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    @(posedge clk);
    rd(6'(ADDR_OUT_BASE + 3), 8'h00);
    rd(ADDR_IN_BASE, {3'b000, IN_SEL_RESET[4:0]});
    idle;
    check(8'(periph_in[8]), 8'(pin_in[IN_SEL_RESET[44:40]]));
    idle;
    report_and_stop;
  end
endmodule
